// ---- core/fblp_pkg.sv ----
// Shared constants and carriers for the flash block lock protection logic.
package fblp_pkg;

   // -----------------------------------------------------------------
   // Geometry and command set
   // -----------------------------------------------------------------
   localparam int NUM_BLOCKS = 8;
   localparam int BLK_W = 3;
   localparam int ADDR_W = 8;

   // Block index sits above a 16-word sub-block offset.
   localparam int BLK_LSB = 4;
   localparam logic [3:0] LOCK_STATUS_OFS = 4'h2;

   // Software register map of this block.
   localparam logic [ADDR_W-1:0] CMD_REG = 8'h00;
   localparam logic [ADDR_W-1:0] OP_REG = 8'h01;
   localparam logic [ADDR_W-1:0] STATUS_REG = 8'h02;
   localparam logic [ADDR_W-1:0] LOCKSTAT_BASE = 8'h80;

   // Command codes written to CMD_REG bits 7:0, block in bits 10:8.
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_SIGNATURE = 8'h90;
   localparam logic [7:0] CMD_LOCK = 8'h01;
   localparam logic [7:0] CMD_UNLOCK = 8'hD0;
   localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_PROG_SUSPEND = 8'hB1;
   localparam logic [7:0] CMD_RESUME = 8'hD1;
   localparam int CMD_BLK_LSB = 8;

   // Status register fields.
   localparam int ST_PROTECT_BIT = 1;
   localparam int ST_PSUSP_BIT = 2;
   localparam int ST_VPP_BIT = 3;
   localparam int ST_ESUSP_BIT = 6;

   // OP_REG write: bit 0 program, bit 1 erase, block in bits 10:8.
   localparam int OP_PROG_BIT = 0;
   localparam int OP_ERASE_BIT = 1;

   // Reset values of the per-block flags.
   localparam logic LOCK_RESET = 1'b1;
   localparam logic LOCKDOWN_RESET = 1'b0;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } fblp_bus_t;

   typedef struct packed {
      logic grant;
      logic refuse;
      logic [BLK_W-1:0] blk;
      logic erase;
   } fblp_op_t;

endpackage : fblp_pkg

// ---- core/fblp_core.sv ----
// Per-block lock, lock-down and write-protect logic with its register port.
`timescale 1ns/100ps
// How it works
// R1 - Lock and unlock commands change the addressed block's flags next cycle.
// R2 - Supply at or below lockout refuses every program and erase.
// R3 - Signature command enables lock-status reads at each block location.
// R4 - Lock status word at block offset 2: bit0 lock, bit1 lock-down.
// R5 - Lock sets lock flag, unlock clears it, lock-down also sets it.
// R6 - Lock-down flag set by command, cleared only by reset.
// R7 - After reset every block is locked and not locked-down.
// R8 - Program or erase on a locked block is refused and flagged.
// R9 - Program and erase allowed only when lock flag is clear.
// R10 - Lock-down command sets both flags whatever write-protect level.
// R11 - Protect low: locked-down blocks ignore lock commands, refuse writes.
// R12 - Protect high: locked-down blocks may be unlocked and relocked freely.
// R13 - Protect falling relocks every locked-down block.
// R14 - Protect rising restores lock flag held before it last fell.
// R15 - Reset returns all blocks to locked, clearing lock-down.
// R16 - Lock commands are accepted during erase suspend.
// R17 - Host suspends erase and waits before changing locks.
// R18 - Relocking a suspended block does not cancel its resumed erase.
// R19 - Lock commands are ignored while a program is suspended.
// R20 - Protect edges leave blocks without lock-down untouched.
// R21 - Protection error bit stays set until clear status or reset.
module fblp_core (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic resetn,
   // Register port.
   input wire fblp_pkg::fblp_bus_t busIn,
   output logic [31:0] rdData,
   // Pins from outside the clock domain.
   input wire logic writeProtectIn,
   input wire logic vppLowIn,
   // Operation result toward the program/erase engine.
   output fblp_pkg::fblp_op_t opOut
);

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic wpMeta;
   logic wpSync;
   logic wpPrev;
   logic vppMeta;
   logic vppSync;

   // Two flops each; only the second stage is read by logic.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wpMeta <= 1'b0;
         wpSync <= 1'b0;
         vppMeta <= 1'b1;
         vppSync <= 1'b1;
      end else begin
         wpMeta <= writeProtectIn;
         wpSync <= wpMeta;
         vppMeta <= vppLowIn;
         vppSync <= vppMeta;
      end
   end

   // Previous protect level, for edge detection on the synced copy.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wpPrev <= 1'b0;
      end else begin
         wpPrev <= wpSync;
      end
   end

   wire wpFall = wpPrev && !wpSync;
   wire wpRise = !wpPrev && wpSync;

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   logic [7:0] cmdCode;
   logic [fblp_pkg::BLK_W-1:0] cmdBlk;
   logic cmdWr;
   logic opWr;

   always_comb begin
      cmdWr = busIn.wr && (busIn.addr == fblp_pkg::CMD_REG);
      opWr = busIn.wr && (busIn.addr == fblp_pkg::OP_REG);
      cmdCode = busIn.wdata[7:0];
      cmdBlk = busIn.wdata[fblp_pkg::CMD_BLK_LSB +: fblp_pkg::BLK_W];
   end

   // Suspend state of the program/erase engine as seen by software.
   logic eraseSusp;
   logic progSusp;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         eraseSusp <= 1'b0;
         progSusp <= 1'b0;
      end else if (cmdWr) begin
         if (cmdCode == fblp_pkg::CMD_ERASE_SUSPEND) begin
            eraseSusp <= 1'b1;
         end else if (cmdCode == fblp_pkg::CMD_PROG_SUSPEND) begin
            progSusp <= 1'b1;
         end else if (cmdCode == fblp_pkg::CMD_RESUME) begin
            eraseSusp <= 1'b0;
            progSusp <= 1'b0;
         end
      end
   end

   // Signature-read mode, entered and left by command.
   logic sigMode;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sigMode <= 1'b0;
      end else if (cmdWr) begin
         if (cmdCode == fblp_pkg::CMD_SIGNATURE) begin
            sigMode <= 1'b1; // see R3
         end else if (cmdCode == fblp_pkg::CMD_READ_ARRAY) begin
            sigMode <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Per-block flags
   // -----------------------------------------------------------------
   logic [fblp_pkg::NUM_BLOCKS-1:0] lockFlag;
   logic [fblp_pkg::NUM_BLOCKS-1:0] lockdownFlag;
   logic [fblp_pkg::NUM_BLOCKS-1:0] savedLock;
   logic [fblp_pkg::NUM_BLOCKS-1:0] next_lockFlag;

   // Lock commands are dropped while a program is suspended.
   wire lockCmdOk = cmdWr && !progSusp; // see R19 R16

   // Protect edges act first; a same-cycle command then overrides the
   // addressed block so that no command is lost.
   always_comb begin
      next_lockFlag = lockFlag;
      for (int i = 0; i < fblp_pkg::NUM_BLOCKS; i++) begin
         if (lockdownFlag[i] && wpFall) begin
            next_lockFlag[i] = 1'b1; // see R13
         end else if (lockdownFlag[i] && wpRise) begin
            next_lockFlag[i] = savedLock[i]; // see R14
         end
      end
      if (lockCmdOk && (!lockdownFlag[cmdBlk] || wpSync)) begin // see R11
         unique case (cmdCode)
            fblp_pkg::CMD_LOCK: next_lockFlag[cmdBlk] = 1'b1; // see R5 R12
            fblp_pkg::CMD_UNLOCK: next_lockFlag[cmdBlk] = 1'b0; // see R1
            fblp_pkg::CMD_LOCKDOWN: next_lockFlag[cmdBlk] = 1'b1; // see R10
            default: ;
         endcase
      end
   end

   // Reset forces every block locked, never locked-down.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lockFlag <= {fblp_pkg::NUM_BLOCKS{fblp_pkg::LOCK_RESET}}; // see R7
      end else begin
         lockFlag <= next_lockFlag; // see R20
      end
   end

   // Only reset clears the lock-down flag.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lockdownFlag <= {fblp_pkg::NUM_BLOCKS{fblp_pkg::LOCKDOWN_RESET}};
      end else if (lockCmdOk && cmdCode == fblp_pkg::CMD_LOCKDOWN) begin
         lockdownFlag[cmdBlk] <= 1'b1; // see R6 R15
      end
   end

   // Lock value captured when protect falls, held while it is low, restored on the next rise.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         savedLock <= {fblp_pkg::NUM_BLOCKS{fblp_pkg::LOCK_RESET}};
      end else if (wpFall) begin
         savedLock <= lockFlag; // see R14
      end
   end

   // -----------------------------------------------------------------
   // Program / erase gate
   // -----------------------------------------------------------------
   logic [fblp_pkg::BLK_W-1:0] opBlk;
   logic opReq;
   logic opRefuse;

   // Lock flag alone covers all protected states from the cycle after protect falls, since the
   // lock-down paths set it on the fall and keep it set while protect stays low.
   always_comb begin
      opBlk = busIn.wdata[fblp_pkg::CMD_BLK_LSB +: fblp_pkg::BLK_W];
      opReq = opWr && (busIn.wdata[fblp_pkg::OP_PROG_BIT]
                       || busIn.wdata[fblp_pkg::OP_ERASE_BIT]);
      opRefuse = vppSync || lockFlag[opBlk]; // see R2 R8 R9
   end

   // Result of each request; a resumed erase is never cancelled here.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         opOut <= '0;
      end else begin
         opOut.grant <= opReq && !opRefuse; // see R18
         opOut.refuse <= opReq && opRefuse;
         opOut.blk <= opBlk;
         opOut.erase <= busIn.wdata[fblp_pkg::OP_ERASE_BIT];
      end
   end

   // -----------------------------------------------------------------
   // Status bits
   // -----------------------------------------------------------------
   logic protErr;
   logic vppErr;

   // Set wins over a clear arriving in the same cycle.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         protErr <= 1'b0;
         vppErr <= 1'b0;
      end else begin
         if (opReq && lockFlag[opBlk]) begin
            protErr <= 1'b1; // see R21
         end else if (cmdWr && cmdCode == fblp_pkg::CMD_CLEAR_STATUS) begin
            protErr <= 1'b0;
         end
         if (opReq && vppSync) begin
            vppErr <= 1'b1;
         end else if (cmdWr && cmdCode == fblp_pkg::CMD_CLEAR_STATUS) begin
            vppErr <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   logic [31:0] next_rdData;
   logic [fblp_pkg::BLK_W-1:0] rdBlk;

   // Lock-status word: base + block*16 + 2, visible in signature mode.
   always_comb begin
      next_rdData = 32'h0000_0000;
      rdBlk = busIn.addr[fblp_pkg::BLK_LSB +: fblp_pkg::BLK_W];
      if (busIn.addr == fblp_pkg::STATUS_REG) begin
         next_rdData[fblp_pkg::ST_PROTECT_BIT] = protErr;
         next_rdData[fblp_pkg::ST_PSUSP_BIT] = progSusp;
         next_rdData[fblp_pkg::ST_VPP_BIT] = vppErr;
         next_rdData[fblp_pkg::ST_ESUSP_BIT] = eraseSusp;
      end else if (sigMode && busIn.addr[7] &&
                   busIn.addr[3:0] == fblp_pkg::LOCK_STATUS_OFS) begin
         next_rdData[0] = lockFlag[rdBlk]; // see R4 R3
         next_rdData[1] = lockdownFlag[rdBlk];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdData <= 32'h0000_0000;
      end else if (busIn.rd) begin
         rdData <= next_rdData;
      end else begin
         rdData <= 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   AST_LOCK_CMD: assert property (@(posedge sys_clk) disable iff (!resetn)
      (lockCmdOk && cmdCode == fblp_pkg::CMD_LOCK) |=> lockFlag[$past(cmdBlk)])
      else $error("lock command did not set lock flag"); // see R5
   AST_UNLOCK_LD_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
      (cmdWr && lockdownFlag[cmdBlk] && !wpSync && !wpRise)
      |=> lockFlag[$past(cmdBlk)])
      else $error("locked-down block changed with protect low"); // see R11
   AST_LD_STICKY: assert property (@(posedge sys_clk) disable iff (!resetn)
      (lockdownFlag != '0) |=> ((lockdownFlag & $past(lockdownFlag))
                                 == $past(lockdownFlag)))
      else $error("lock-down flag cleared by software"); // see R6
   AST_WP_FALL: assert property (@(posedge sys_clk) disable iff (!resetn)
      wpFall |=> ((lockFlag & $past(lockdownFlag)) == $past(lockdownFlag)))
      else $error("locked-down block not relocked"); // see R13
   AST_REFUSE: assert property (@(posedge sys_clk) disable iff (!resetn)
      (opReq && lockFlag[opBlk]) |=> (opOut.refuse && !opOut.grant))
      else $error("write on locked block not refused"); // see R8
   AST_VPP: assert property (@(posedge sys_clk) disable iff (!resetn)
      (opReq && vppSync) |=> !opOut.grant)
      else $error("write granted under supply lockout"); // see R2
   AST_PERR: assert property (@(posedge sys_clk) disable iff (!resetn)
      (protErr && !(cmdWr && cmdCode == fblp_pkg::CMD_CLEAR_STATUS))
      |=> protErr)
      else $error("protection error dropped without clear"); // see R21
   AST_PSUSP: assert property (@(posedge sys_clk) disable iff (!resetn)
      (cmdWr && progSusp && !wpFall && !wpRise) |=> $stable(lockFlag))
      else $error("lock changed during program suspend"); // see R19
   AST_NO_LD_WP: assert property (@(posedge sys_clk) disable iff (!resetn)
      (wpFall && lockdownFlag == '0 && !cmdWr) |=> $stable(lockFlag))
      else $error("protect edge moved unrelated block"); // see R20

endmodule : fblp_core

// ---- verification/fblp_host.sv ----
// Host-side bus master model that drives the lock block's register port.
`timescale 1ns/100ps
module fblp_host (
   // Clock.
   input wire logic sys_clk,
   // Register port.
   input wire logic [31:0] rdData,
   output fblp_pkg::fblp_bus_t busOut
);
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   // The port idles with both strobes low from time zero.
   initial busOut = '0;

   // One-cycle write; address and data are held through the strobe edge.
   task write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      busOut <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      busOut.wr <= 1'b0;
   endtask : write

   // One-cycle read; the data stand only in the cycle after the strobe.
   task read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      busOut <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge sys_clk);
      busOut.rd <= 1'b0;
      #1 d = rdData;
   endtask : read

   // Suspends the erase and polls up to 16 status reads until suspend is reported.
   task suspend_erase(output bit ok);
      logic [31:0] d;
      write(fblp_pkg::CMD_REG, {24'h00_0000, fblp_pkg::CMD_ERASE_SUSPEND});
      ok = 0;
      for (int i = 0; i < 16 && !ok; i++) begin
         read(fblp_pkg::STATUS_REG, d);
         ok = d[fblp_pkg::ST_ESUSP_BIT];
      end
   endtask : suspend_erase
endmodule : fblp_host

// ---- verification/fblp_core_test.sv ----
// Self-checking bench for the block lock logic against a flag model.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin \
   fail_count++; $display("Error %s expected %0h seen %0h", nm, e, g); \
   end end
module fblp_core_test;
   logic sys_clk = 0;
   logic resetn = 0;
   logic writeProtectIn = 1;
   logic vppLowIn = 0;
   fblp_pkg::fblp_bus_t busIn;
   logic [31:0] rdData;
   logic [31:0] d;
   fblp_pkg::fblp_op_t opOut;
   int fail_count = 0;
   int check_count = 0;
   bit lk[8], ld[8], sv[8];
   bit wp = 1, vpp, errP, errV, eSus, pSus, ok;
   logic [7:0] codes [4] = '{fblp_pkg::CMD_LOCK, fblp_pkg::CMD_UNLOCK,
      fblp_pkg::CMD_LOCKDOWN, fblp_pkg::CMD_CLEAR_STATUS};

   fblp_core fblp_core_i (.sys_clk(sys_clk), .resetn(resetn),
      .busIn(busIn), .rdData(rdData), .writeProtectIn(writeProtectIn),
      .vppLowIn(vppLowIn), .opOut(opOut));
   fblp_host fblp_host_i (.sys_clk(sys_clk), .rdData(rdData),
      .busOut(busIn));

   // Free-running 125 MHz clock.
   always #4 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // Model and bus helpers
   // ----------------------------------------------------------------
   // Reset waits three edges so that both pin syncs settle.
   task do_reset;
      // Align to a rising edge, since a read leaves us just after one.
      @(posedge sys_clk);
      resetn <= 0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1;
      for (int b = 0; b < 8; b++) begin
         lk[b] = 1;
         ld[b] = 0;
         sv[b] = 1;
      end
      {errP, errV, eSus, pSus} = 0;
      repeat (3) @(posedge sys_clk);
   endtask : do_reset

   // Writes a command and applies it to the model.
   task cmd(input logic [7:0] c, input int b);
      bit free;
      fblp_host_i.write(fblp_pkg::CMD_REG, {21'h0, 3'(b), c});
      free = !pSus && !(ld[b] && !wp);
      case (c)
         fblp_pkg::CMD_LOCK: if (free) lk[b] = 1;
         fblp_pkg::CMD_UNLOCK: if (free) lk[b] = 0;
         fblp_pkg::CMD_LOCKDOWN: if (!pSus) {ld[b], lk[b]} = 2'b11;
         fblp_pkg::CMD_CLEAR_STATUS: {errP, errV} = 0;
         fblp_pkg::CMD_PROG_SUSPEND: pSus = 1;
         fblp_pkg::CMD_RESUME: {eSus, pSus} = 0;
         default: ;
      endcase
   endtask : cmd

   // Reads one block's lock status word in signature mode.
   task chk_blk(input int b);
      fblp_host_i.read(fblp_pkg::LOCKSTAT_BASE + 8'(b * 16) +
         8'(fblp_pkg::LOCK_STATUS_OFS), d);
      `CHK("lockStatus", {ld[b], lk[b]}, d[1:0])
   endtask : chk_blk

   task chk_status;
      fblp_host_i.read(fblp_pkg::STATUS_REG, d);
      `CHK("status", {eSus, errV, pSus, errP}, {d[6], d[3:1]})
   endtask : chk_status

   // Requests program or erase; the answer is a pulse in the next cycle.
   task op(input int b, input bit er);
      bit r;
      fblp_host_i.write(fblp_pkg::OP_REG, {21'h0, 3'(b), 6'h00, er, !er});
      r = lk[b] || vpp;
      #1;
      `CHK("grant", !r, opOut.grant)
      `CHK("refuse", r, opOut.refuse)
      `CHK("blk", 3'(b), opOut.blk)
      `CHK("erase", er, opOut.erase)
      // A locked target flags a protection error even under lockout.
      errP |= lk[b];
      errV |= vpp;
   endtask : op

   // Changes the protect pin and applies its edge to the model.
   task set_wp(input bit v);
      @(posedge sys_clk);
      writeProtectIn <= v;
      repeat (3) @(posedge sys_clk);
      for (int b = 0; b < 8 && v != wp; b++) begin
         if (!v) begin
            sv[b] = lk[b];
            if (ld[b]) lk[b] = 1;
         end else if (ld[b]) lk[b] = sv[b];
      end
      wp = v;
   endtask : set_wp

   task tally_and_finish;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // A hang is cut short and counted as a mismatch.
   initial begin
      repeat (100000) @(posedge sys_clk);
      fail_count++;
      tally_and_finish;
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h40db));
      do_reset;
      // Lock status is hidden until signature mode; unmapped reads are 0.
      fblp_host_i.read(8'h40, d);
      `CHK("unmapped", 32'h0000_0000, d)
      fblp_host_i.read(fblp_pkg::LOCKSTAT_BASE + 8'h02, d);
      `CHK("noSig", 2'b00, d[1:0])
      cmd(fblp_pkg::CMD_SIGNATURE, 0);
      for (int b = 0; b < 8; b++) chk_blk(b);
      op(3, 0);
      chk_status;
      // Unlock then at once erase: no latency allowed.
      cmd(fblp_pkg::CMD_UNLOCK, 3);
      op(3, 1);
      // Random mix of commands, requests and protect edges.
      repeat (300) begin
         case ($urandom % 8)
            0, 1, 2, 3: cmd(codes[$urandom % 4], $urandom % 8);
            4: op($urandom % 8, $urandom % 2);
            5: set_wp(!wp);
            6: chk_blk($urandom % 8);
            default: chk_status;
         endcase
      end
      for (int b = 0; b < 8; b++) chk_blk(b);
      // Lock-down during erase suspend, then resume.
      set_wp(1);
      cmd(fblp_pkg::CMD_UNLOCK, 5);
      fblp_host_i.suspend_erase(ok);
      eSus = 1;
      `CHK("suspendSeen", 1'b1, ok)
      cmd(fblp_pkg::CMD_LOCKDOWN, 5);
      chk_blk(5);
      chk_status;
      cmd(fblp_pkg::CMD_RESUME, 0);
      // Lock commands are ignored while a program is suspended.
      cmd(fblp_pkg::CMD_PROG_SUSPEND, 0);
      cmd(fblp_pkg::CMD_UNLOCK, 6);
      cmd(fblp_pkg::CMD_LOCKDOWN, 2);
      chk_blk(6);
      chk_blk(2);
      chk_status;
      cmd(fblp_pkg::CMD_RESUME, 0);
      // Supply lockout refuses an unlocked block.
      cmd(fblp_pkg::CMD_UNLOCK, 1);
      vppLowIn <= 1;
      vpp = 1;
      repeat (3) @(posedge sys_clk);
      op(1, 1);
      chk_status;
      @(posedge sys_clk);
      vppLowIn <= 0;
      vpp = 0;
      repeat (3) @(posedge sys_clk);
      cmd(fblp_pkg::CMD_CLEAR_STATUS, 0);
      chk_status;
      // Leaving signature mode hides the lock status again.
      cmd(fblp_pkg::CMD_READ_ARRAY, 0);
      fblp_host_i.read(fblp_pkg::LOCKSTAT_BASE + 8'h52, d);
      `CHK("sigLeft", 2'b00, d[1:0])
      // A second reset clears lock-down and relocks every block.
      do_reset;
      cmd(fblp_pkg::CMD_SIGNATURE, 0);
      for (int b = 0; b < 8; b++) chk_blk(b);
      chk_status;
      tally_and_finish;
   end
endmodule : fblp_core_test
